// [flash_program_erase_control.sv]
// Overview of operation
// - Emulated block reads return overlay RAM data
// - Overlay must be released before real programming
// - 256k array: 3x64k, 1x32k, 8x4k blocks
// - Erase whole blocks only; erased reads ones
// - Control registers need gate bit set
// - Decode six registers on low address bits
// - Flash disabled: control registers read zero
// - Write level without soft enable zeroes error and block registers
// - Control registers: byte access, two states
// - Mode register resets to 0x80, standby too
// - Setup and verify bits need soft enable
// - Go bits need soft enable plus setup
// - Mode bit 7 reads one, read only
// - Soft enable: array reads valid only verifying or on overlay hits
// - Bit 1 erase mode, bit 0 program
// - Multiple block bits clear both block registers
// - Error flag blocks operations until reset, hardware standby or write level without soft enable
// - Overlay on protects all blocks
`timescale 1ns/100ps
module flash_program_erase_control (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic flash_enabled,
	input wire logic hw_write_level,
	input wire logic error_event,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic cpu_byte,
	output logic [7:0] cpu_rdata,
	output logic cpu_ready,
	input wire logic ovl_wr,
	input wire logic [flash_ctl_pkg::OVL_AW-1:0] ovl_addr,
	input wire logic [7:0] ovl_wdata,
	input wire logic fl_rd,
	input wire logic [flash_ctl_pkg::FLASH_AW-1:0] fl_addr,
	input wire logic [7:0] flash_array_data,
	output logic [7:0] fl_rd_data,
	output logic fl_rd_valid,
	output logic program_active,
	output logic erase_active,
	output logic program_verify_on,
	output logic erase_verify_on,
	output logic protect_on,
	output logic [flash_ctl_pkg::NUM_BLOCKS-1:0] erase_block_mask,
	output logic [flash_ctl_pkg::FLASH_AW-1:0] erase_base_addr,
	output logic [flash_ctl_pkg::FLASH_AW-1:0] erase_size
);
	typedef enum logic {ACC_IDLE, ACC_DONE} acc_e;

	acc_e acc_r, acc_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [6:0] mode_r, mode_nxt;
	logic err_r, err_nxt;
	logic gate_r, gate_nxt;
	logic [3:0] ovl_r, ovl_nxt;
	logic [7:0] eb_lo;
	logic [flash_ctl_pkg::EBHI_W-1:0] eb_hi;
	logic take, ctl_ok, wr_ctl, wr_eblo, wr_ebhi, force_zero, standby_clr;
	logic soft_write_enable, erase_setup, program_setup;
	logic [flash_ctl_pkg::NUM_BLOCKS-1:0] eb_sel;
	logic [3:0] eb_idx;

	// Pipeline of the array read path
	logic rd1_r, rd1_nxt, hit1_r, hit1_nxt, ok1_r, ok1_nxt;
	logic [7:0] fdat1_r, fdat1_nxt;
	logic [7:0] out_r, out_nxt;
	logic val_r, val_nxt;
	logic [7:0] ram_rdata;
	logic ovl_hit;

	function automatic logic is_ctl_addr(input logic [15:0] a);
		is_ctl_addr = (a == flash_ctl_pkg::ADDR_MODE) || (a == flash_ctl_pkg::ADDR_ERR) ||
			(a == flash_ctl_pkg::ADDR_EBLO) || (a == flash_ctl_pkg::ADDR_EBHI);
	endfunction : is_ctl_addr

	assign soft_write_enable = mode_r[flash_ctl_pkg::MODE_SWE];
	assign erase_setup = mode_r[flash_ctl_pkg::MODE_ESU];
	assign program_setup = mode_r[flash_ctl_pkg::MODE_PSU];
	// A request is taken only while the bus port is idle
	assign take = (acc_r == ACC_IDLE) && (cpu_rd || cpu_wr);
	// Control registers answer only with the gate set, flash on and a byte access
	assign ctl_ok = gate_r && flash_enabled && cpu_byte;
	assign wr_ctl = take && cpu_wr && ctl_ok && is_ctl_addr(cpu_addr);
	assign wr_eblo = wr_ctl && (cpu_addr == flash_ctl_pkg::ADDR_EBLO);
	assign wr_ebhi = wr_ctl && (cpu_addr == flash_ctl_pkg::ADDR_EBHI);
	// Write level without soft enable holds error and block registers at zero
	assign force_zero = hw_write_level && !soft_write_enable;
	assign standby_clr = hw_standby || sw_standby;

	// Bus access: taken in one cycle, answered the next, two states in all
	always_comb begin
		acc_nxt = acc_r;
		rdata_nxt = rdata_r;
		case (acc_r)
			ACC_IDLE: begin
				if (take) begin
					acc_nxt = ACC_DONE;
					rdata_nxt = flash_ctl_pkg::READ_ZERO;
					if (cpu_rd) begin
						case (cpu_addr)
							flash_ctl_pkg::ADDR_OVERLAY: begin
								rdata_nxt = {4'h0, ovl_r};
							end
							flash_ctl_pkg::ADDR_GATE: begin
								rdata_nxt[flash_ctl_pkg::GATE_BIT] = gate_r;
							end
							flash_ctl_pkg::ADDR_MODE: begin
								if (ctl_ok) begin
									rdata_nxt = {1'b1, mode_r};
								end
							end
							flash_ctl_pkg::ADDR_ERR: begin
								if (ctl_ok) begin
									rdata_nxt[flash_ctl_pkg::ERR_FLAG_BIT] = err_r;
								end
							end
							flash_ctl_pkg::ADDR_EBLO: begin
								if (ctl_ok) begin
									rdata_nxt = eb_lo;
								end
							end
							flash_ctl_pkg::ADDR_EBHI: begin
								if (ctl_ok) begin
									rdata_nxt = {4'h0, eb_hi};
								end
							end
							default: begin
								rdata_nxt = flash_ctl_pkg::READ_ZERO;
							end
						endcase
					end
				end
			end
			ACC_DONE: begin
				acc_nxt = ACC_IDLE;
			end
			default: begin
				acc_nxt = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= ACC_IDLE;
			rdata_r <= flash_ctl_pkg::READ_ZERO;
		end else begin
			acc_r <= acc_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign cpu_ready = (acc_r == ACC_DONE);
	assign cpu_rdata = rdata_r;

	// Control and status registers
	always_comb begin
		mode_nxt = mode_r;
		err_nxt = err_r;
		gate_nxt = gate_r;
		ovl_nxt = ovl_r;
		if (take && cpu_wr && cpu_addr == flash_ctl_pkg::ADDR_GATE) begin
			gate_nxt = cpu_wdata[flash_ctl_pkg::GATE_BIT];
		end
		if (take && cpu_wr && cpu_addr == flash_ctl_pkg::ADDR_OVERLAY) begin
			ovl_nxt = cpu_wdata[3:0];
		end
		if (wr_ctl && cpu_addr == flash_ctl_pkg::ADDR_MODE) begin
			mode_nxt[flash_ctl_pkg::MODE_SWE] = cpu_wdata[flash_ctl_pkg::MODE_SWE];
			// Gated bits judge their condition on the value before this write
			if (soft_write_enable) begin
				mode_nxt[flash_ctl_pkg::MODE_ESU] = cpu_wdata[flash_ctl_pkg::MODE_ESU];
				mode_nxt[flash_ctl_pkg::MODE_PSU] = cpu_wdata[flash_ctl_pkg::MODE_PSU];
				mode_nxt[flash_ctl_pkg::MODE_EV] = cpu_wdata[flash_ctl_pkg::MODE_EV];
				mode_nxt[flash_ctl_pkg::MODE_PV] = cpu_wdata[flash_ctl_pkg::MODE_PV];
			end
			if (soft_write_enable && erase_setup) begin
				mode_nxt[flash_ctl_pkg::MODE_ERASE] = cpu_wdata[flash_ctl_pkg::MODE_ERASE];
			end
			if (soft_write_enable && program_setup) begin
				mode_nxt[flash_ctl_pkg::MODE_PROG] = cpu_wdata[flash_ctl_pkg::MODE_PROG];
			end
			// Bits whose condition fails simply keep their old value
		end
		// Either standby resets the mode register like a chip reset
		if (standby_clr) begin
			mode_nxt = flash_ctl_pkg::MODE_RESET[6:0];
		end
		if (force_zero || hw_standby) begin
			err_nxt = 1'b0;
		end
		// A new error outranks any clear in the same cycle
		if (error_event) begin
			err_nxt = 1'b1;
		end
		if (hw_standby) begin
			gate_nxt = flash_ctl_pkg::GATE_RESET[flash_ctl_pkg::GATE_BIT];
			ovl_nxt = flash_ctl_pkg::OVL_RESET[3:0];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= flash_ctl_pkg::MODE_RESET[6:0];
			err_r <= flash_ctl_pkg::ERR_RESET[flash_ctl_pkg::ERR_FLAG_BIT];
			gate_r <= flash_ctl_pkg::GATE_RESET[flash_ctl_pkg::GATE_BIT];
			ovl_r <= flash_ctl_pkg::OVL_RESET[3:0];
		end else begin
			mode_r <= mode_nxt;
			err_r <= err_nxt;
			gate_r <= gate_nxt;
			ovl_r <= ovl_nxt;
		end
	end

	// Erase block registers, wiped when more than one block is selected
	erase_block_select u_ebs (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clear(force_zero || standby_clr),
		.wr_lo(wr_eblo),
		.wr_hi(wr_ebhi),
		.wdata(cpu_wdata),
		.lo_r(eb_lo),
		.hi_r(eb_hi)
	);

	// Program and erase drive, with error and overlay protection
	assign protect_on = err_r || ovl_r[flash_ctl_pkg::OVL_ON_BIT];
	assign program_active = mode_r[flash_ctl_pkg::MODE_PROG] && soft_write_enable && !protect_on;
	assign eb_sel = {eb_hi, eb_lo};
	assign eb_idx = flash_ctl_pkg::block_index(eb_sel);
	assign erase_active = mode_r[flash_ctl_pkg::MODE_ERASE] && soft_write_enable && !protect_on &&
		(eb_sel != '0);
	assign erase_block_mask = erase_active ? eb_sel : '0;
	assign erase_base_addr = erase_active ? flash_ctl_pkg::block_base(eb_idx) : '0;
	assign erase_size = erase_active ? flash_ctl_pkg::block_size(eb_idx) : '0;
	assign program_verify_on = soft_write_enable && mode_r[flash_ctl_pkg::MODE_PV];
	assign erase_verify_on = soft_write_enable && mode_r[flash_ctl_pkg::MODE_EV];

	// Array reads: emulated 4k block comes from the overlay RAM
	assign ovl_hit = ovl_r[flash_ctl_pkg::OVL_ON_BIT] &&
		(fl_addr[flash_ctl_pkg::FLASH_AW-1:flash_ctl_pkg::OVL_AW] ==
		{3'h0, ovl_r[flash_ctl_pkg::OVL_AREA_W-1:0]});

	// Overlay RAM is filled from its own port and read on emulated hits
	overlay_ram u_ram (
		.ref_clk(ref_clk),
		.wr_en(ovl_wr),
		.wr_addr(ovl_addr),
		.wr_data(ovl_wdata),
		.rd_en(fl_rd && ovl_hit),
		.rd_addr(fl_addr[flash_ctl_pkg::OVL_AW-1:0]),
		.rd_data_r(ram_rdata)
	);

	always_comb begin
		rd1_nxt = fl_rd;
		hit1_nxt = fl_rd && ovl_hit;
		// Overlay data stays valid whatever the soft enable says
		ok1_nxt = ovl_hit || !soft_write_enable || mode_r[flash_ctl_pkg::MODE_PV] ||
			mode_r[flash_ctl_pkg::MODE_EV];
		fdat1_nxt = flash_enabled ? flash_array_data : flash_ctl_pkg::ERASED_BYTE;
		out_nxt = out_r;
		val_nxt = rd1_r && ok1_r;
		if (rd1_r) begin
			out_nxt = hit1_r ? ram_rdata : fdat1_r;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd1_r <= 1'b0;
			hit1_r <= 1'b0;
			ok1_r <= 1'b0;
			fdat1_r <= flash_ctl_pkg::ERASED_BYTE;
			out_r <= flash_ctl_pkg::ERASED_BYTE;
			val_r <= 1'b0;
		end else begin
			rd1_r <= rd1_nxt;
			hit1_r <= hit1_nxt;
			ok1_r <= ok1_nxt;
			fdat1_r <= fdat1_nxt;
			out_r <= out_nxt;
			val_r <= val_nxt;
		end
	end

	assign fl_rd_data = out_r;
	assign fl_rd_valid = val_r;
endmodule : flash_program_erase_control

// [flash_ctl_pkg.sv]
package flash_ctl_pkg;

	// Register addresses, low 16 address bits
	localparam logic [15:0] ADDR_OVERLAY = 16'hfedb;
	localparam logic [15:0] ADDR_GATE = 16'hff42;
	localparam logic [15:0] ADDR_MODE = 16'hffc8;
	localparam logic [15:0] ADDR_ERR = 16'hffc9;
	localparam logic [15:0] ADDR_EBLO = 16'hffca;
	localparam logic [15:0] ADDR_EBHI = 16'hffcb;

	// Values after reset
	localparam logic [7:0] MODE_RESET = 8'h80;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [7:0] EB_RESET = 8'h00;
	localparam logic [7:0] GATE_RESET = 8'h00;
	localparam logic [7:0] OVL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Mode control fields
	localparam int MODE_HW_LOCK = 7;
	localparam int MODE_SWE = 6;
	localparam int MODE_ESU = 5;
	localparam int MODE_PSU = 4;
	localparam int MODE_EV = 3;
	localparam int MODE_PV = 2;
	localparam int MODE_ERASE = 1;
	localparam int MODE_PROG = 0;

	// Other fields
	localparam int ERR_FLAG_BIT = 7;
	localparam int GATE_BIT = 3;
	localparam int OVL_ON_BIT = 3;
	localparam int OVL_AREA_W = 3;
	localparam int EBHI_W = 4;

	// Array geometry
	localparam int FLASH_AW = 18;
	localparam int NUM_BLOCKS = 12;
	localparam int SMALL_BLOCKS = 8;
	localparam int OVL_AW = 12;
	localparam int OVL_DEPTH = 4096;
	localparam logic [FLASH_AW-1:0] SMALL_SIZE = 18'h01000;
	localparam logic [FLASH_AW-1:0] MID_BASE = 18'h08000;
	localparam logic [FLASH_AW-1:0] MID_SIZE = 18'h08000;
	localparam logic [FLASH_AW-1:0] BIG_BASE = 18'h10000;
	localparam logic [FLASH_AW-1:0] BIG_SIZE = 18'h10000;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Bus access length in clock cycles
	localparam int ACCESS_STATES = 2;

	typedef logic [FLASH_AW-1:0] faddr_t;

	function automatic faddr_t block_base(input logic [3:0] idx);
		if (idx < 4'h8) begin
			block_base = SMALL_SIZE * faddr_t'(idx);
		end else if (idx == 4'h8) begin
			block_base = MID_BASE;
		end else begin
			block_base = BIG_BASE + BIG_SIZE * faddr_t'(idx - 4'h9);
		end
	endfunction : block_base

	function automatic faddr_t block_size(input logic [3:0] idx);
		if (idx < 4'h8) begin
			block_size = SMALL_SIZE;
		end else if (idx == 4'h8) begin
			block_size = MID_SIZE;
		end else begin
			block_size = BIG_SIZE;
		end
	endfunction : block_size

	function automatic logic [3:0] block_index(input logic [NUM_BLOCKS-1:0] sel);
		block_index = 4'h0;
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			if (sel[i]) begin
				block_index = 4'(i);
			end
		end
	endfunction : block_index

endpackage : flash_ctl_pkg

// [overlay_ram.sv]
`timescale 1ns/100ps
module overlay_ram (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [flash_ctl_pkg::OVL_AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [flash_ctl_pkg::OVL_AW-1:0] rd_addr,
	output logic [7:0] rd_data_r
);
	logic [7:0] mem [flash_ctl_pkg::OVL_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_r <= mem[rd_addr];
		end
	end
endmodule : overlay_ram

// [erase_block_select.sv]
`timescale 1ns/100ps
module erase_block_select (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	output logic [7:0] lo_r,
	output logic [flash_ctl_pkg::EBHI_W-1:0] hi_r
);
	logic [7:0] lo_nxt;
	logic [flash_ctl_pkg::EBHI_W-1:0] hi_nxt;
	logic [flash_ctl_pkg::NUM_BLOCKS-1:0] sel;

	always_comb begin
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		if (wr_lo) begin
			lo_nxt = wdata;
		end
		if (wr_hi) begin
			hi_nxt = wdata[flash_ctl_pkg::EBHI_W-1:0];
		end
		sel = {hi_nxt, lo_nxt};
		// More than one block selected wipes both registers
		if ((sel & (sel - 1'b1)) != '0) begin
			lo_nxt = flash_ctl_pkg::EB_RESET;
			hi_nxt = flash_ctl_pkg::EB_RESET[flash_ctl_pkg::EBHI_W-1:0];
		end
		if (clear) begin
			lo_nxt = flash_ctl_pkg::EB_RESET;
			hi_nxt = flash_ctl_pkg::EB_RESET[flash_ctl_pkg::EBHI_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lo_r <= flash_ctl_pkg::EB_RESET;
			hi_r <= flash_ctl_pkg::EB_RESET[flash_ctl_pkg::EBHI_W-1:0];
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end
endmodule : erase_block_select

// [flash_ctl_properties.sv]
`timescale 1ns/100ps
module flash_ctl_properties (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic flash_enabled,
	input wire logic error_event,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic cpu_ready,
	input wire logic fl_rd,
	input wire logic fl_rd_valid,
	input wire logic program_active,
	input wire logic erase_active,
	input wire logic program_verify_on,
	input wire logic protect_on,
	input wire logic [flash_ctl_pkg::NUM_BLOCKS-1:0] erase_block_mask,
	input wire logic [flash_ctl_pkg::FLASH_AW-1:0] erase_base_addr,
	input wire logic [flash_ctl_pkg::FLASH_AW-1:0] erase_size
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_ready_single: assert property (cpu_ready |=> !cpu_ready)
		else $error("ready held over one cycle");
	a_ready_cause: assert property (cpu_ready |-> $past(cpu_rd || cpu_wr))
		else $error("ready without request");
	a_prog_unprotected: assert property (program_active |-> !protect_on)
		else $error("program while protected");
	a_error_blocks: assert property (error_event |=> protect_on && !program_active && !erase_active)
		else $error("error did not protect");
	a_hw_standby_unprotect: assert property (hw_standby && !error_event && !cpu_wr |=> !protect_on)
		else $error("protect kept after standby");
	a_erase_onehot: assert property (erase_active |-> $onehot(erase_block_mask))
		else $error("erase mask not one block");
	a_mid_block_range: assert property (erase_active && erase_block_mask[8] |->
		erase_base_addr == 18'h08000 && erase_size == 18'h08000)
		else $error("wrong range for block 8");
	a_rd_valid_cause: assert property (fl_rd_valid |-> $past(fl_rd, 2))
		else $error("read valid without read");
	a_verify_read_ok: assert property (fl_rd && program_verify_on && flash_enabled |-> ##2 fl_rd_valid)
		else $error("verify read not valid");
	a_standby_stops: assert property ((hw_standby || sw_standby) && !cpu_wr |=>
		!program_active && !erase_active)
		else $error("mode kept through standby");
endmodule : flash_ctl_properties

bind flash_program_erase_control flash_ctl_properties chk_inst (
	.ref_clk, .arst_n, .hw_standby, .sw_standby, .flash_enabled, .error_event,
	.cpu_rd, .cpu_wr, .cpu_ready, .fl_rd, .fl_rd_valid, .program_active, .erase_active,
	.program_verify_on, .protect_on, .erase_block_mask, .erase_base_addr, .erase_size
);

// [cpu_model.sv]
`timescale 1ns/100ps
module cpu_model (
	input wire logic ref_clk,
	input wire logic cpu_ready,
	input wire logic [7:0] cpu_rdata,
	output logic [15:0] cpu_addr,
	output logic [7:0] cpu_wdata,
	output logic cpu_rd,
	output logic cpu_wr,
	output logic cpu_byte
);
	logic byte_en = 1'b1;
	initial begin
		cpu_addr = 16'h0000;
		cpu_wdata = 8'h00;
		cpu_rd = 1'b0;
		cpu_wr = 1'b0;
		cpu_byte = 1'b1;
	end
	// One access, held through the rising edge after ready and dropped on the next falling edge
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(negedge ref_clk);
		cpu_wr = w;
		cpu_rd = !w;
		cpu_addr = a;
		cpu_wdata = wd;
		cpu_byte = byte_en;
		do begin
			@(negedge ref_clk);
			n++;
		end while (cpu_ready !== 1'b1 && n < 8);
		if (cpu_ready !== 1'b1) begin
			tb_top.error_cnt++;
			tb_top.end_sim();
		end
		@(posedge ref_clk);
		rd = cpu_rdata;
		@(negedge ref_clk);
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_addr = ~a;
		cpu_wdata = ~wd;
	endtask : acc
endmodule : cpu_model

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic hw_standby = 1'b0;
	logic sw_standby = 1'b0;
	logic flash_enabled = 1'b1;
	logic hw_write_level = 1'b1;
	logic error_event = 1'b0;
	logic ovl_wr = 1'b0;
	logic [flash_ctl_pkg::OVL_AW-1:0] ovl_addr = 12'h000;
	logic [7:0] ovl_wdata = 8'h00;
	logic fl_rd = 1'b0;
	logic [flash_ctl_pkg::FLASH_AW-1:0] fl_addr = 18'h00000;
	wire logic [7:0] flash_array_data;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, fl_rd_data, d;
	logic cpu_rd, cpu_wr, cpu_byte, cpu_ready, fl_rd_valid;
	logic program_active, erase_active, program_verify_on, erase_verify_on, protect_on;
	logic [flash_ctl_pkg::NUM_BLOCKS-1:0] erase_block_mask;
	logic [flash_ctl_pkg::FLASH_AW-1:0] erase_base_addr, erase_size;
	int error_cnt = 0;
	int checks = 0;
	// Address, write data, value read back after the write
	logic [31:0] rows [23] = '{
		32'hffc8_40_00, 32'hff42_ff_08, 32'hffc8_00_80, 32'hffc9_ff_00,
		32'hffca_01_00, 32'hffc8_3f_80, 32'hffc8_40_c0, 32'hffc8_50_d0,
		32'hffc8_51_d1, 32'hffc8_50_d0, 32'hffc8_40_c0, 32'hffc8_42_c0,
		32'hffc8_60_e0, 32'hffc8_62_e2, 32'hffca_03_00, 32'hffcb_ff_00,
		32'hffcb_01_01, 32'hffca_01_00, 32'hffcb_01_01, 32'hffc8_48_c8,
		32'hffc8_44_c4, 32'hfedb_ff_0f, 32'h1234_55_00
	};

	always #5 ref_clk = ~ref_clk;
	assign flash_array_data = fl_addr[7:0] ^ 8'h3c;

	flash_program_erase_control flash_program_erase_control_inst (
		.ref_clk, .arst_n, .hw_standby, .sw_standby, .flash_enabled, .hw_write_level,
		.error_event, .cpu_addr, .cpu_wdata, .cpu_rd, .cpu_wr, .cpu_byte, .cpu_rdata,
		.cpu_ready, .ovl_wr, .ovl_addr, .ovl_wdata, .fl_rd, .fl_addr, .flash_array_data,
		.fl_rd_data, .fl_rd_valid, .program_active, .erase_active, .program_verify_on,
		.erase_verify_on, .protect_on, .erase_block_mask, .erase_base_addr, .erase_size
	);
	cpu_model cpu_model_inst (
		.ref_clk, .cpu_ready, .cpu_rdata, .cpu_addr, .cpu_wdata, .cpu_rd, .cpu_wr, .cpu_byte
	);

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		cpu_model_inst.acc(1'b1, a, v, d);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		cpu_model_inst.acc(1'b0, a, 8'h00, d);
	endtask : rd
	task automatic fr(input logic [17:0] a);
		@(negedge ref_clk);
		fl_rd = 1'b1;
		fl_addr = a;
		@(negedge ref_clk);
		fl_rd = 1'b0;
		fl_addr = ~a;
		@(negedge ref_clk);
	endtask : fr
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask : pulse
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (8) @(negedge ref_clk);
		arst_n = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16]);
			`CHK(d, rows[i][7:0])
		end
		$display("test register table done");
		@(negedge ref_clk);
		ovl_wr = 1'b1;
		ovl_addr = 12'h123;
		ovl_wdata = 8'ha5;
		@(negedge ref_clk);
		ovl_wr = 1'b0;
		fr({6'h07, 12'h123});
		`CHK({fl_rd_valid, fl_rd_data}, 9'h1a5)
		`CHK(protect_on, 1'b1)
		fr(18'h00045);
		`CHK({fl_rd_valid, fl_rd_data}, 9'h179)
		wr(16'hfedb, 8'h00);
		wr(16'hffc8, 8'h40);
		`CHK(protect_on, 1'b0)
		fr(18'h00045);
		`CHK(fl_rd_valid, 1'b0)
		$display("test overlay and verify done");
		wr(16'hffc8, 8'h50);
		wr(16'hffc8, 8'h51);
		`CHK(program_active, 1'b1)
		pulse(error_event);
		`CHK(program_active, 1'b0)
		hw_write_level = 1'b0;
		pulse(sw_standby);
		rd(16'hffc9);
		`CHK(d, 8'h80)
		rd(16'hffc8);
		`CHK(d, 8'h80)
		pulse(hw_standby);
		`CHK(protect_on, 1'b0)
		rd(16'hff42);
		`CHK(d, 8'h00)
		hw_write_level = 1'b1;
		$display("test error and standby done");
		wr(16'hff42, 8'h08);
		flash_enabled = 1'b0;
		wr(16'hffc8, 8'h40);
		rd(16'hffc8);
		`CHK(d, 8'h00)
		flash_enabled = 1'b1;
		rd(16'hffc8);
		`CHK(d, 8'h80)
		cpu_model_inst.byte_en = 1'b0;
		rd(16'hffc8);
		`CHK(d, 8'h00)
		cpu_model_inst.byte_en = 1'b1;
		hw_write_level = 1'b0;
		wr(16'hffc8, 8'h40);
		wr(16'hffcb, 8'h02);
		wr(16'hffc8, 8'h60);
		wr(16'hffc8, 8'h62);
		`CHK(erase_active, 1'b1)
		`CHK(erase_block_mask, 12'h200)
		`CHK(erase_base_addr, 18'h10000)
		`CHK(erase_size, 18'h10000)
		wr(16'hffc8, 8'h48);
		`CHK({erase_active, erase_verify_on}, 2'b01)
		wr(16'hffc8, 8'h00);
		pulse(error_event);
		rd(16'hffcb);
		`CHK(d, 8'h02)
		hw_write_level = 1'b1;
		rd(16'hffcb);
		`CHK(d, 8'h00)
		rd(16'hffc9);
		`CHK(d, 8'h00)
		$display("test disable, width and level done");
		hw_write_level = 1'b0;
		pulse(error_event);
		`CHK(protect_on, 1'b1)
		arst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		`CHK({cpu_ready, fl_rd_valid, protect_on}, 3'b000)
		wr(16'hff42, 8'h08);
		rd(16'hffc8);
		`CHK(d, 8'h80)
		$display("test mid-run reset done");
		end_sim();
	end
endmodule : tb_top
